// [pci_group_flag.sv]
// Sticky group flag set by any enabled pin change, cleared by writing one
`timescale 1ns/100ps
module pci_group_flag #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] changed,
  input wire logic [WIDTH-1:0] mask,
  input wire logic clear,
  output logic flag
);
  logic flag_q;
  logic hit;

  if (WIDTH < 1) begin
    $error("pci_group_flag: WIDTH must be at least 1");
  end

  assign hit = |(changed & mask);

  // A change in the clearing cycle wins over the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else if (hit) begin
      flag_q <= 1'b1;
    end else if (clear) begin
      flag_q <= 1'b0;
    end
  end

  assign flag = flag_q;
endmodule

// [pci_irq_properties.sv]
// Port checker of the pin-change interrupt block
`timescale 1ns/100ps
module pci_irq_properties #(
  parameter int C_PINS = 6,
  parameter int D_PINS = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic [C_PINS-1:0] portCPins,
  input wire logic [D_PINS-1:0] portDPins,
  input wire logic portCGroupIrq,
  input wire logic portDGroupIrq,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_wr_rd(a);
    regWrite && regAddr == a ##1 regRead && regAddr == a;
  endsequence
  // Pins quiet long enough that no change is still in the synchroniser
  sequence s_clr_d;
    $stable(portDPins)[*4] ##0 (regWrite && regAddr == 8'h6E && regWrData[1]);
  endsequence
  a_mask_c_rw: assert property (s_wr_rd(8'h6C) |=> regRdData == $past(regWrData, 2))
    else $error("port C mask readback");
  a_mask_d_rw: assert property (s_wr_rd(8'h6D) |=> regRdData == $past(regWrData, 2))
    else $error("port D mask readback");
  a_rd_idle_zero: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data outside slot");
  a_unmapped_zero: assert property (regRead && regAddr > 8'h70 |=> regRdData == 8'h00)
    else $error("unmapped read");
  a_global_off: assert property (regWrite && regAddr == 8'h70 && !regWrData[0] |=> !irq)
    else $error("irq without global");
  a_group_d_off: assert property (regWrite && regAddr == 8'h6F && !regWrData[1] |=> !portDGroupIrq)
    else $error("D request without enable");
  a_clear_d_flag: assert property (s_clr_d |=> !portDGroupIrq)
    else $error("D flag not cleared");
  a_irq_or: assert property (irq == (portCGroupIrq || portDGroupIrq))
    else $error("irq not OR of groups");
  a_group_c_off: assert property (regWrite && regAddr == 8'h6F && !regWrData[0] |=> !portCGroupIrq)
    else $error("C request without enable");
  // A request only rises after a register write or a pin change three samples back
  a_c_irq_cause: assert property ($rose(portCGroupIrq) |-> $past(regWrite) || $past(portCPins, 3) != $past(portCPins, 4))
    else $error("C request without cause");
  a_d_irq_cause: assert property ($rose(portDGroupIrq) |-> $past(regWrite) || $past(portDPins, 3) != $past(portDPins, 4))
    else $error("D request without cause");
endmodule
bind pci_pin_change_irq pci_irq_properties #(.C_PINS(C_PINS), .D_PINS(D_PINS)) u_props (.*);

// [pci_pin_change_irq.sv]
// Top of the pin-change interrupt block for port C and port D pin groups
// Behaviour
// - Port C mask bits 5..0 enable pin changes
// - Enabled port C change sets group flag
// - Request needs flag, group enable, global enable
// - Cleared mask bit ignores that pin
// - Port D mask at 0x6D, reset zero
// - Port D mask bit n enables pin n
// - Port C mask at 0x6C, reset zero
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
module pci_pin_change_irq
  import pci_pkg::*;
#(
  parameter int C_PINS = PCI_PORT_C_PINS,
  parameter int D_PINS = PCI_PORT_D_PINS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [PCI_ADDR_W-1:0] regAddr,
  input wire logic [PCI_DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [PCI_DATA_W-1:0] regRdData,
  input wire logic [C_PINS-1:0] portCPins,
  input wire logic [D_PINS-1:0] portDPins,
  output logic portCGroupIrq,
  output logic portDGroupIrq,
  output logic irq
);
  logic [PCI_DATA_W-1:0] portCChangeMask_q;
  logic [PCI_DATA_W-1:0] portDChangeMask_q;
  logic [1:0] groupEnable_q;
  logic globalEnable_q;
  logic [PCI_DATA_W-1:0] regRdData_q;
  logic [PCI_DATA_W-1:0] regRdData_d;
  logic [C_PINS-1:0] portCChanged;
  logic [D_PINS-1:0] portDChanged;
  logic portCGroupFlag;
  logic portDGroupFlag;
  logic flagWrite;
  logic [1:0] flags;

  // Port C has six pins behind its mask; more could not be served
  if (C_PINS < 1 || C_PINS > PCI_PORT_C_PINS) begin
    $error("pci_pin_change_irq: C_PINS must be 1 to 6");
  end
  if (D_PINS < 1 || D_PINS > PCI_DATA_W) begin
    $error("pci_pin_change_irq: D_PINS must be 1 to 8");
  end

  // Mask registers; all eight bits of each are software read/write
  always_ff @(posedge clk) begin
    if (reset) begin
      portCChangeMask_q <= PCI_MASK_RESET;
    end else if (regWrite && regAddr == PCI_OFS_PORT_C_MASK) begin
      portCChangeMask_q <= regWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      portDChangeMask_q <= PCI_MASK_RESET;
    end else if (regWrite && regAddr == PCI_OFS_PORT_D_MASK) begin
      portDChangeMask_q <= regWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      groupEnable_q <= PCI_ENABLE_RESET;
    end else if (regWrite && regAddr == PCI_OFS_ENABLE) begin
      groupEnable_q <= regWrData[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      globalEnable_q <= PCI_GLOBAL_RESET;
    end else if (regWrite && regAddr == PCI_OFS_GLOBAL) begin
      globalEnable_q <= regWrData[PCI_BIT_GLOBAL];
    end
  end

  pci_pin_sync #(.WIDTH(C_PINS)) portCSync (
    .clk(clk),
    .reset(reset),
    .pinIn(portCPins),
    .changed(portCChanged)
  );

  pci_pin_sync #(.WIDTH(D_PINS)) portDSync (
    .clk(clk),
    .reset(reset),
    .pinIn(portDPins),
    .changed(portDChanged)
  );

  assign flagWrite = regWrite && regAddr == PCI_OFS_FLAGS;

  // Mask bit n gates pin n only; bits 7..6 of port C have no pin here
  pci_group_flag #(.WIDTH(C_PINS)) portCFlag (
    .clk(clk),
    .reset(reset),
    .changed(portCChanged),
    .mask(portCChangeMask_q[C_PINS-1:0]),
    .clear(flagWrite && regWrData[PCI_BIT_PORT_C]),
    .flag(portCGroupFlag)
  );

  pci_group_flag #(.WIDTH(D_PINS)) portDFlag (
    .clk(clk),
    .reset(reset),
    .changed(portDChanged),
    .mask(portDChangeMask_q[D_PINS-1:0]),
    .clear(flagWrite && regWrData[PCI_BIT_PORT_D]),
    .flag(portDGroupFlag)
  );

  assign flags = {portDGroupFlag, portCGroupFlag};

  // Group enable acts as the mask; global enable gates both requests
  assign portCGroupIrq = portCGroupFlag && groupEnable_q[PCI_BIT_PORT_C] && globalEnable_q;
  assign portDGroupIrq = portDGroupFlag && groupEnable_q[PCI_BIT_PORT_D] && globalEnable_q;
  assign irq = portCGroupIrq || portDGroupIrq;

  // Unmapped addresses read as zero
  always_comb begin
    regRdData_d = '0;
    case (regAddr)
      PCI_OFS_PORT_C_MASK: regRdData_d = portCChangeMask_q;
      PCI_OFS_PORT_D_MASK: regRdData_d = portDChangeMask_q;
      PCI_OFS_FLAGS: regRdData_d = {6'h00, flags};
      PCI_OFS_ENABLE: regRdData_d = {6'h00, groupEnable_q};
      PCI_OFS_GLOBAL: regRdData_d = {7'h00, globalEnable_q};
      default: regRdData_d = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      regRdData_q <= '0;
    end else if (regRead) begin
      regRdData_q <= regRdData_d;
    end else begin
      regRdData_q <= '0;
    end
  end

  assign regRdData = regRdData_q;
endmodule

// [pci_pin_change_irq_tb_top.sv]
// Testbench of the pin-change interrupt block
`timescale 1ns/100ps
module pci_pin_change_irq_tb_top;
  logic clk = 0, reset = 1, regWrite = 0, regRead = 0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, dTog = 8'h00, regRdData, portDPins;
  logic [5:0] cTog = 6'h00, portCPins;
  logic portCGroupIrq, portDGroupIrq, irq;
  int n_mismatch = 0, compares = 0;
  pci_pin_change_irq u_dut (.*);
  pci_pin_model u_pins (.*);
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 0;
  endtask
  // Follows a write with no gap when called straight after one
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    if (!regWrite) @(posedge clk);
    regRead <= 1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 0;
    #1 chk(regRdData, e);
  endtask
  task automatic tg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    cTog <= a[0] ? 6'h00 : m[5:0];
    dTog <= a[0] ? m : 8'h00;
    @(posedge clk);
    cTog <= 6'h00;
    dTog <= 8'h00;
    repeat (5) @(posedge clk);
    #1 chk({5'h00, portCGroupIrq, portDGroupIrq, irq}, e);
  endtask
  task automatic t_regs;
    for (logic [7:0] a = 8'h6C; a < 8'h72; a++) rd(a, 8'h00);
    wr(8'h6C, 8'hC3);
    rd(8'h6C, 8'hC3);
    wr(8'h6D, 8'h5A);
    rd(8'h6D, 8'h5A);
    wr(8'h71, 8'hFF);
    rd(8'h71, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_pins(input logic [7:0] a, input int n);
    logic [7:0] m;
    logic [7:0] e;
    e = a[0] ? 8'h03 : 8'h05;
    for (int i = 0; i < n; i++) begin
      m = 8'h01 << i;
      wr(a, ~m);
      tg(a, m, 8'h00);
      wr(a, m);
      tg(a, m, e);
      wr(8'h6E, 8'h03);
      tg(a, m, e);
      wr(8'h6E, 8'h03);
    end
    $display("t_pins done");
  endtask
  task automatic t_gate;
    wr(8'h6D, 8'h01);
    tg(8'h6D, 8'h01, 8'h03);
    wr(8'h70, 8'h00);
    tg(8'h6D, 8'h00, 8'h00);
    wr(8'h70, 8'h01);
    wr(8'h6F, 8'h01);
    tg(8'h6D, 8'h00, 8'h00);
    wr(8'h6F, 8'h03);
    tg(8'h6D, 8'h00, 8'h03);
    wr(8'h6E, 8'h02);
    tg(8'h6D, 8'h00, 8'h00);
    $display("t_gate done");
  endtask
  task automatic t_gate_c;
    wr(8'h6C, 8'h01);
    tg(8'h6C, 8'h01, 8'h05);
    wr(8'h70, 8'h00);
    tg(8'h6C, 8'h00, 8'h00);
    wr(8'h70, 8'h01);
    wr(8'h6F, 8'h02);
    tg(8'h6C, 8'h00, 8'h00);
    wr(8'h6F, 8'h03);
    tg(8'h6C, 8'h00, 8'h05);
    rd(8'h6E, 8'h01);
    wr(8'h6E, 8'h01);
    tg(8'h6C, 8'h00, 8'h00);
    $display("t_gate_c done");
  endtask
  // Reset in mid-run must bring masks, flags and requests back to zero
  task automatic t_reset;
    wr(8'h6D, 8'hFF);
    tg(8'h6D, 8'h01, 8'h03);
    @(posedge clk);
    reset <= 1;
    repeat (3) @(posedge clk);
    reset <= 0;
    #1 chk({5'h00, portCGroupIrq, portDGroupIrq, irq}, 8'h00);
    rd(8'h6D, 8'h00);
    rd(8'h6C, 8'h00);
    rd(8'h6E, 8'h00);
    $display("t_reset done");
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 0;
    t_regs;
    wr(8'h6F, 8'h03);
    wr(8'h70, 8'h01);
    t_pins(8'h6C, 6);
    t_pins(8'h6D, 8);
    t_gate;
    t_gate_c;
    t_reset;
    give_verdict;
  end
  // About 550 cycles are expected; the limit leaves ample margin
  initial begin
    #20000;
    n_mismatch++;
    $display("Error %0t: watchdog limit reached", $time);
    give_verdict;
  end
endmodule

// [pci_pin_model.sv]
// Model of the external port pins, toggled on command
`timescale 1ns/100ps
module pci_pin_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [5:0] cTog,
  input wire logic [7:0] dTog,
  output logic [5:0] portCPins,
  output logic [7:0] portDPins
);
  // Pins move just after a rising edge; the block still treats them as asynchronous
  always @(posedge clk) begin
    if (reset) begin
      portCPins <= 6'h00;
      portDPins <= 8'h00;
    end else begin
      portCPins <= portCPins ^ cTog;
      portDPins <= portDPins ^ dTog;
    end
  end
endmodule

// [pci_pin_sync.sv]
// Two-stage synchroniser with change detection for a group of pins
`timescale 1ns/100ps
module pci_pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] changed
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;
  logic primed_q;

  // Refused at elaboration, before any logic is built
  if (WIDTH < 1) begin
    $error("pci_pin_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
      primed_q <= 1'b0;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
      primed_q <= 1'b1;
    end
  end

  // Gate only the first cycle after reset, where sync_q and prev_q are still zero; a pin high at release still counts; both edges count
  assign changed = primed_q ? (sync_q ^ prev_q) : '0;
endmodule

// [pci_pkg.sv]
// Package of register offsets, field positions and reset values for the pin-change block
package pci_pkg;
  localparam int PCI_ADDR_W = 8;
  localparam int PCI_DATA_W = 8;
  localparam logic [7:0] PCI_OFS_PORT_C_MASK = 8'h6C;
  localparam logic [7:0] PCI_OFS_PORT_D_MASK = 8'h6D;
  localparam logic [7:0] PCI_OFS_FLAGS = 8'h6E;
  localparam logic [7:0] PCI_OFS_ENABLE = 8'h6F;
  localparam logic [7:0] PCI_OFS_GLOBAL = 8'h70;
  localparam logic [7:0] PCI_MASK_RESET = 8'h00;
  localparam logic [1:0] PCI_FLAGS_RESET = 2'h0;
  localparam logic [1:0] PCI_ENABLE_RESET = 2'h0;
  localparam logic PCI_GLOBAL_RESET = 1'b0;
  localparam int PCI_BIT_PORT_C = 0;
  localparam int PCI_BIT_PORT_D = 1;
  localparam int PCI_BIT_GLOBAL = 0;
  localparam int PCI_PORT_C_PINS = 6;
  localparam int PCI_PORT_D_PINS = 8;
endpackage
